// ### logic/rcl_top.sv
// reset configuration loader: option byte load, processor stall, watchdog preset
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R01] any reset returns all control bits and outputs to defined reset values
// [R02] processor held stalled until the configuration load has completed
// [R03] double-bit fault during load leaves protection and security active
// [R04] reset during program or erase aborts it at once; target left undefined
// [R05] RAM is neither cleared nor initialised by reset
// [R06] option register loaded from configuration byte at global address 3_FF0E
// [R07] watchdog rate field and window bit initialised from option register
// [R08] watchdog rate is bitwise inverse of the option nonvolatile field
// [R09] option load completes before its bits reach the watchdog controls
module rcl_top
  import rcl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic nv_data_valid,
  input wire logic [7:0] nv_rdata,
  input wire logic nv_double_fault,
  input wire logic cmd_active,
  output logic nv_read_req,
  output logic [17:0] nv_read_addr,
  output logic cpu_stall,
  output logic cmd_abort,
  output logic protect_active,
  output logic secure_active,
  output logic [7:0] option_byte_register,
  output logic [2:0] watchdog_rate_field,
  output logic watchdog_window_bit,
  output logic ram_init_req
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {RCL_ABORT, RCL_READ, RCL_STORE, RCL_DONE} rcl_state_t;
  rcl_state_t state_reg, state_next;
  logic [7:0] opt_mem_rdata;
  logic [1:0] lat_reg;
  logic fault_reg;
  rcl_wdog_t wdog_next;
  rcl_nv_req_t nv_req_next;
  logic abort_next;
  logic [1:0] lat_next;
  logic stall_next;
  // the array answer is taken only in the read phase; a stray or late valid is ignored
  wire store_en = (state_reg == RCL_READ) && nv_data_valid;
  wire read_done = (state_reg == RCL_STORE) && (lat_reg == 2'(RCL_READ_LAT - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RCL_ABORT: state_next = RCL_READ;
      RCL_READ: if (store_en) state_next = RCL_STORE;
      RCL_STORE: if (read_done) state_next = RCL_DONE;
      RCL_DONE: state_next = RCL_DONE;
    endcase
  end

  // rate is the inverted option field, the window bit is copied as it is
  assign wdog_next = '{rate: ~opt_mem_rdata[RCL_RATE_LSB +: RCL_RATE_W],
                       window: opt_mem_rdata[RCL_WIN_POS]}; // see [R08]

  // next values are plain decodes so the register blocks below stay a few lines each
  assign nv_req_next = '{req: (state_next == RCL_READ), addr: RCL_OPT_ADDR}; // see [R06]
  assign abort_next = (state_reg == RCL_ABORT) && cmd_active; // see [R04]
  assign lat_next = (state_reg == RCL_STORE) ? lat_reg + 2'h1 : 2'h0;
  assign stall_next = (state_next != RCL_DONE); // see [R02]

  rcl_opt_mem u_mem (
    .core_clk(core_clk),
    .we(store_en),
    .waddr(2'h0),
    .wdata(nv_rdata),
    .raddr(2'h0),
    .rdata(opt_mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and read-back latency; every register takes a constant on reset, see [R01]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= RCL_ABORT;
      lat_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      lat_reg <= lat_next;
    end
  end

  // abort is high through reset and, if cmd_active is set, one cycle after it, never later; see [R04]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_abort <= 1'b1;
    end else begin
      cmd_abort <= abort_next;
    end
  end

  // read request and its fixed address toward the array
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_read_req <= 1'b0;
      nv_read_addr <= RCL_OPT_ADDR;
    end else begin
      nv_read_req <= nv_req_next.req; // see [R06]
      nv_read_addr <= nv_req_next.addr; // see [R06]
    end
  end

  // option byte and fault flag come from one array answer, so they are captured together
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b0;
      option_byte_register <= RCL_OPT_RESET;
    end else if (store_en) begin
      fault_reg <= nv_double_fault; // see [R03]
      option_byte_register <= nv_rdata; // see [R06]
    end
  end

  // watchdog copy waits for the stored byte to read back; see [R09]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdog_rate_field <= RCL_RATE_RESET;
      watchdog_window_bit <= 1'b0;
    end else if (read_done) begin
      watchdog_rate_field <= wdog_next.rate; // see [R07]
      watchdog_window_bit <= wdog_next.window; // see [R07]
    end
  end

  // a faulted load keeps protection and security on until the next reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      protect_active <= 1'b0;
      secure_active <= 1'b0;
    end else if (read_done) begin
      protect_active <= fault_reg; // see [R03]
      secure_active <= fault_reg; // see [R03]
    end
  end

  // release falls on the same edge as the watchdog copy, never before it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_stall <= 1'b1;
    end else begin
      cpu_stall <= stall_next; // see [R02]
    end
  end

  // ram keeps whatever it held: no initialisation request is ever raised
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ram_init_req <= 1'b0; // see [R05]
    end else begin
      ram_init_req <= 1'b0; // see [R05]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_stall_until_done: assert property (@(posedge core_clk) disable iff (rst) // see [R02]
    (state_reg != RCL_DONE) |-> cpu_stall) else $error("processor released before load done");
  chk_release_after_copy: assert property (@(posedge core_clk) disable iff (rst) // see [R09]
    $fell(cpu_stall) |-> $past(read_done)) else $error("stall released without watchdog copy");
  chk_rate_inverse: assert property (@(posedge core_clk) disable iff (rst) // see [R08]
    $fell(cpu_stall) |-> watchdog_rate_field == ~option_byte_register[RCL_RATE_LSB +: RCL_RATE_W])
    else $error("rate not inverse");
  chk_window_copy: assert property (@(posedge core_clk) disable iff (rst) // see [R07]
    !cpu_stall |-> watchdog_window_bit == option_byte_register[RCL_WIN_POS]) else $error("window bit mismatch");
  chk_opt_load: assert property (@(posedge core_clk) disable iff (rst) // see [R06]
    store_en |=> option_byte_register == $past(nv_rdata)) else $error("option byte not loaded");
  chk_read_addr: assert property (@(posedge core_clk) disable iff (rst) // see [R06]
    nv_read_req |-> nv_read_addr == RCL_OPT_ADDR) else $error("wrong option address");
  chk_fault_protect: assert property (@(posedge core_clk) disable iff (rst) // see [R03]
    store_en && nv_double_fault |-> ##[1:3] (protect_active && secure_active)) else $error("fault not protected");
  chk_abort_first: assert property (@(posedge core_clk) disable iff (rst) // see [R04]
    cmd_abort |-> $past(state_reg == RCL_ABORT)) else $error("abort outside reset exit");
  chk_no_ram_init: assert property (@(posedge core_clk) disable iff (rst) // see [R05]
    !ram_init_req) else $error("ram init requested");
  chk_stall_at_start: assert property (@(posedge core_clk) disable iff (rst) // see [R01]
    (state_reg == RCL_READ) |-> cpu_stall && !protect_active) else $error("reset state wrong");

  // reset exit: outputs at their reset values, abort follows the command flag once
  chk_reset_state: assert property (@(posedge core_clk) disable iff (rst) // see [R01]
    $rose(nv_read_req) |-> cpu_stall && !protect_active && !secure_active && !watchdog_window_bit
    && (option_byte_register == RCL_OPT_RESET) && (watchdog_rate_field == RCL_RATE_RESET))
    else $error("outputs not at reset values when the load starts");
  chk_abort_follow: assert property (@(posedge core_clk) disable iff (rst) // see [R04]
    (state_reg == RCL_ABORT) |=> (cmd_abort == $past(cmd_active)))
    else $error("abort does not follow the running command");
  chk_abort_clear: assert property (@(posedge core_clk) disable iff (rst) // see [R04]
    cmd_abort && (state_reg != RCL_ABORT) |=> !cmd_abort)
    else $error("abort longer than one cycle");
  chk_req_only_read: assert property (@(posedge core_clk) disable iff (rst) // see [R06]
    nv_read_req |-> (state_reg == RCL_READ))
    else $error("read request outside the read phase");

  // load timing, counted from the edge that stores the option byte
  chk_req_drop: assert property (@(posedge core_clk) disable iff (rst) // see [R06]
    store_en |=> !nv_read_req)
    else $error("read request kept after the byte arrived");
  chk_store_span: assert property (@(posedge core_clk) disable iff (rst) // see [R09]
    store_en |=> (state_reg == RCL_STORE) [*2] ##1 (state_reg == RCL_DONE))
    else $error("read-back phase has the wrong length");
  chk_copy_timing: assert property (@(posedge core_clk) disable iff (rst) // see [R02]
    store_en |-> ##2 cpu_stall ##1 !cpu_stall)
    else $error("processor released at the wrong cycle");
  chk_done_sticky: assert property (@(posedge core_clk) disable iff (rst) // see [R02]
    (state_reg == RCL_DONE) |=> (state_reg == RCL_DONE) && !nv_read_req && !cpu_stall)
    else $error("second load without a reset");

  // outputs after the load
  chk_fault_quiet: assert property (@(posedge core_clk) disable iff (rst) // see [R03]
    store_en && !nv_double_fault |-> ##3 (!protect_active && !secure_active))
    else $error("protection set without a fault");
  chk_watch_hold: assert property (@(posedge core_clk) disable iff (rst) // see [R09]
    cpu_stall |-> (watchdog_rate_field == RCL_RATE_RESET) && !watchdog_window_bit)
    else $error("watchdog changed while still stalled");
  chk_opt_hold: assert property (@(posedge core_clk) disable iff (rst) // see [R07]
    !cpu_stall |=> $stable(option_byte_register) && $stable(watchdog_rate_field)
    && $stable(watchdog_window_bit))
    else $error("loaded configuration changed after release");
  chk_secure_pair: assert property (@(posedge core_clk) disable iff (rst) // see [R03]
    protect_active == secure_active)
    else $error("protection and security differ");
endmodule
`default_nettype wire

// ### logic/rcl_pkg.sv
// package of constants and carrier types for the reset configuration loader
package rcl_pkg;
  localparam logic [17:0] RCL_OPT_ADDR = 18'h3ff0e;
  localparam logic [15:0] RCL_WDOG_CTRL_ADDR = 16'h003c;
  localparam int RCL_RATE_W = 3;
  localparam int RCL_RATE_LSB = 0;
  localparam int RCL_WIN_POS = 6;
  localparam logic [7:0] RCL_OPT_RESET = 8'hff;
  localparam logic [2:0] RCL_RATE_RESET = 3'h0;
  localparam int RCL_MEM_DEPTH = 4;
  localparam int RCL_READ_LAT = 2;

  typedef struct packed {
    logic [RCL_RATE_W-1:0] rate;
    logic window;
  } rcl_wdog_t;

  typedef struct packed {
    logic req;
    logic [17:0] addr;
  } rcl_nv_req_t;
endpackage

// ### logic/rcl_opt_mem.sv
// small register file holding loaded configuration bytes
`timescale 1ns/1ns
`default_nettype none
module rcl_opt_mem
  import rcl_pkg::*;
(
  input wire logic core_clk,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] raddr,
  output logic [7:0] rdata
);
  // no reset: entry 0, the only one written, is reloaded on every reset sequence
  logic [7:0] mem [RCL_MEM_DEPTH];
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### sim/rcl_nv_model.sv
// array model answering the option byte read after a set delay
`timescale 1ns/1ns
`default_nettype none
module rcl_nv_model
  import rcl_pkg::*;
(
  input wire logic core_clk,
  input wire logic nv_read_req,
  input wire logic [17:0] nv_read_addr,
  input wire logic [7:0] opt_byte,
  input wire logic fault,
  input wire logic [3:0] delay,
  output logic nv_data_valid,
  output logic [7:0] nv_rdata,
  output logic nv_double_fault
);
  int cnt = 0;
  logic go;
  initial {nv_data_valid, nv_rdata, nv_double_fault} = 10'h0a5;
  always @(negedge core_clk) begin
    cnt = nv_read_req ? cnt + 1 : 0;
    // only the configuration byte address answers
    go = nv_read_req && cnt > delay && nv_read_addr == RCL_OPT_ADDR;
    nv_data_valid <= go;
    // idle lines toggle so a stale byte never looks valid
    nv_rdata <= go ? opt_byte : ~nv_rdata;
    nv_double_fault <= go ? fault : ~nv_double_fault;
  end
endmodule
`default_nettype wire

// ### sim/test_reset_config_loader.sv
// randomised reset loads of the option byte with corner values
`timescale 1ns/1ns
`default_nettype none
module test_reset_config_loader
  import rcl_pkg::*;
;
  logic core_clk = 0, rst = 1, cmd_active = 0, fault = 0;
  logic [7:0] ob = 8'h00;
  logic [3:0] dly = 4'h0;
  logic vld, dfl, req, stall, abrt, prot, sec, win, rinit;
  logic [7:0] rdat, opt;
  logic [17:0] addr;
  logic [2:0] rate;
  int fail_count = 0, n_checks = 0, cyc = 0, seed = 32'h03463890;
  rcl_top dut_u (.core_clk(core_clk), .rst(rst), .nv_data_valid(vld), .nv_rdata(rdat),
    .nv_double_fault(dfl), .cmd_active(cmd_active), .nv_read_req(req), .nv_read_addr(addr),
    .cpu_stall(stall), .cmd_abort(abrt), .protect_active(prot), .secure_active(sec),
    .option_byte_register(opt), .watchdog_rate_field(rate), .watchdog_window_bit(win),
    .ram_init_req(rinit));
  rcl_nv_model nv_u (.core_clk(core_clk), .nv_read_req(req), .nv_read_addr(addr),
    .opt_byte(ob), .fault(fault), .delay(dly), .nv_data_valid(vld), .nv_rdata(rdat),
    .nv_double_fault(dfl));
  initial forever #50 core_clk = ~core_clk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [2:0] exp_rate(logic [7:0] b);
    return ~b[RCL_RATE_LSB +: RCL_RATE_W];
  endfunction
  task automatic run_one(logic [7:0] b, logic f, logic c);
    int k;
    @(negedge core_clk);
    rst = 1;
    ob = b;
    fault = f;
    cmd_active = c;
    dly = 4'($random(seed));
    @(negedge core_clk);
    chk(stall, 1);
    chk(opt, RCL_OPT_RESET);
    chk(rate, RCL_RATE_RESET);
    chk({req, win, prot, sec, abrt}, 32'h01);
    chk(addr, RCL_OPT_ADDR);
    rst = 0;
    @(negedge core_clk);
    chk(abrt, c);
    chk(req, 1);
    @(negedge core_clk);
    chk(abrt, 0);
    k = 0;
    // the watchdog must not see the byte while the core is still held
    while (stall === 1 && k < 40) begin
      chk(rate, RCL_RATE_RESET);
      @(negedge core_clk);
      k++;
    end
    chk(stall, 0);
    chk(req, 0);
    chk(opt, b);
    chk(rate, exp_rate(b));
    chk(win, b[RCL_WIN_POS]);
    chk({prot, sec}, {f, f});
    chk(rinit, 0);
    $display("test done opt %h fault %b cmd %b", b, f, c);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge core_clk);
    run_one(8'h00, 0, 1);
    run_one(8'hff, 1, 0);
    run_one(8'h03, 0, 1);
    for (int i = 0; i < 20; i++)
      run_one(8'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    give_verdict();
  end
endmodule
`default_nettype wire
